// [src/lane_steer.sv]
/*
  Data width lane steering bridge: turns 32- and 16-bit internal requests
  into transfers on 32-, 16- or 8-bit external memory.
  Assumes mem_width_i is static configuration on clock_i and the memory
  answers a read strobe within the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lane_steer_params.svh"

module lane_steer (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire lane_steer_pkg::mem_width_t mem_width_i,
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic cpu_size32_i,
  input wire logic [21:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_hi_i,
  input wire logic [15:0] cpu_wdata_lo_i,
  output logic cpu_ready_o,
  output logic cpu_resp_valid_o,
  input wire logic cpu_resp_ready_i,
  output logic [15:0] cpu_rdata_hi_o,
  output logic [15:0] cpu_rdata_lo_o,
  input wire logic dma_req_i,
  input wire logic dma_we_i,
  input wire logic dma_size32_i,
  input wire logic [21:0] dma_addr_i,
  input wire logic [31:0] dma_wdata_i,
  output logic dma_ready_o,
  output logic dma_resp_valid_o,
  input wire logic dma_resp_ready_i,
  output logic [31:0] dma_rdata_o,
  output logic [19:0] mem_addr_o,
  output logic [3:0] mem_byte_lane_enable_n_o,
  output logic mem_strobe_o,
  output logic mem_we_o,
  input wire logic [31:0] mem_data_i,
  output logic [31:0] mem_data_o,
  output logic mem_data_oe_n_o
);
  import lane_steer_pkg::*;

  state_t state;
  // Arbiter outputs
  logic req_valid;
  logic req_ready;
  logic req_src;
  logic req_we;
  logic req_size32;
  logic [21:0] req_addr;
  logic [31:0] req_wdata;
  // Latched access
  logic acc_src;
  logic acc_we;
  logic acc_size32;
  logic [21:0] acc_addr;
  mem_width_t acc_width;
  // Even-first word image for writes
  logic [31:0] acc_wimg;
  // Current and last beat
  logic [1:0] beat;
  logic [1:0] last_beat;
  logic [1:0] next_first;
  logic [1:0] next_last;
  // Memory base address
  logic [19:0] base_addr;
  // Read data synchroniser and tag pipe
  logic [31:0] rd_meta;
  logic [31:0] rd_sync;
  logic tag1;
  logic tag2;
  logic [1:0] tag1_beat;
  logic [1:0] tag2_beat;
  // Even-first read image, byte 0 is [31:24]
  logic [31:0] rd_img;
  // Response path
  logic [31:0] next_rdata;
  logic resp_push;
  logic resp_ready;
  logic resp_valid;
  logic [32:0] resp_data;
  logic resp_sel_ready;

  // Source selection
  request_arbiter u_arb (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .cpu_req_i(cpu_req_i),
    .cpu_we_i(cpu_we_i),
    .cpu_size32_i(cpu_size32_i),
    .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i({cpu_wdata_hi_i, cpu_wdata_lo_i}),
    .cpu_ready_o(cpu_ready_o),
    .dma_req_i(dma_req_i),
    .dma_we_i(dma_we_i),
    .dma_size32_i(dma_size32_i),
    .dma_addr_i(dma_addr_i),
    .dma_wdata_i(dma_wdata_i),
    .dma_ready_o(dma_ready_o),
    .req_valid_o(req_valid),
    .req_ready_i(req_ready),
    .req_src_o(req_src),
    .req_we_o(req_we),
    .req_size32_o(req_size32),
    .req_addr_o(req_addr),
    .req_wdata_o(req_wdata)
  );

  // New request only when idle
  assign req_ready = (state == ST_IDLE);

  // First and last beat of the incoming access
  always_comb
  begin
    next_first = 2'h0;
    unique case (mem_width_i)
      `MW_16: next_last = `LAST_16;
      `MW_8: next_last = `LAST_8;
      default: next_last = `LAST_32;
    endcase
    if (req_we && !req_size32)
    begin
      // Single word write touches only its own lanes
      if (mem_width_i == `MW_16)
      begin
        next_first = {1'b0, req_addr[1]};
        next_last = {1'b0, req_addr[1]};
      end
      else if (mem_width_i == `MW_8)
      begin
        next_first = {req_addr[1], 1'b0};
        next_last = {req_addr[1], 1'b1};
      end
    end
  end

  // Latch accepted request
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      acc_src <= 1'b0;
      acc_we <= 1'b0;
      acc_size32 <= 1'b0;
      acc_addr <= '0;
      acc_width <= `MW_32;
      acc_wimg <= '0;
      last_beat <= 2'h0;
    end
    else if (req_valid && req_ready)
    begin
      acc_src <= req_src;
      acc_we <= req_we;
      acc_size32 <= req_size32;
      acc_addr <= req_addr;
      acc_width <= (mem_width_i == `MW_16 || mem_width_i == `MW_8) ? mem_width_i : `MW_32;
      last_beat <= next_last;
      if (!req_size32)
      begin
        acc_wimg <= {req_wdata[15:0], req_wdata[15:0]};
      end
      else if (req_addr[1])
      begin
        acc_wimg <= {req_wdata[15:0], req_wdata[31:16]};
      end
      else
      begin
        acc_wimg <= req_wdata;
      end
    end
  end

  // Even-aligned base address per width
  always_comb
  begin
    unique case (acc_width)
      `MW_16: base_addr = {acc_addr[20:2], 1'b0};
      `MW_8: base_addr = {acc_addr[19:2], 2'h0};
      default: base_addr = acc_addr[21:2];
    endcase
  end

  // Sequencer
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      state <= ST_IDLE;
      beat <= 2'h0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (req_valid)
          begin
            state <= ST_XFER;
            beat <= next_first;
          end
        end
        ST_XFER:
        begin
          // Beats go out back to back
          beat <= beat + 2'h1;
          if (beat == last_beat)
          begin
            state <= acc_we ? ST_RESP : ST_DRAIN;
          end
        end
        ST_DRAIN:
        begin
          // Wait for the last read beat to land
          if (tag2 && !tag1 && !mem_strobe_o)
          begin
            state <= ST_RESP;
          end
        end
        ST_RESP:
        begin
          if (resp_ready)
          begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Drive one memory beat per XFER cycle
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      mem_strobe_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= '0;
      mem_byte_lane_enable_n_o <= `BE_NONE;
      mem_data_o <= '0;
      mem_data_oe_n_o <= 1'b1;
    end
    else if (state == ST_XFER)
    begin
      mem_strobe_o <= 1'b1;
      mem_we_o <= acc_we;
      mem_data_oe_n_o <= !acc_we;
      mem_addr_o <= base_addr + {18'h0, beat};
      unique case (acc_width)
        `MW_16:
        begin
          mem_byte_lane_enable_n_o <= `BE_LO;
          mem_data_o <= {16'h0, beat[0] ? acc_wimg[15:0] : acc_wimg[31:16]};
        end
        `MW_8:
        begin
          mem_byte_lane_enable_n_o <= `BE_B0;
          mem_data_o <= {24'h0, acc_wimg[8 * (3 - beat) +: 8]};
        end
        default:
        begin
          mem_data_o <= acc_wimg;
          if (acc_we && !acc_size32)
          begin
            mem_byte_lane_enable_n_o <= acc_addr[1] ? `BE_LO : `BE_HI;
          end
          else
          begin
            mem_byte_lane_enable_n_o <= `BE_ALL;
          end
        end
      endcase
    end
    else
    begin
      mem_strobe_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_byte_lane_enable_n_o <= `BE_NONE;
      mem_data_oe_n_o <= 1'b1;
    end
  end

  // Pin data synchroniser, first stage read only by second
  always_ff @(posedge clock_i)
  begin
    rd_meta <= mem_data_i;
    rd_sync <= rd_meta;
  end

  // Read tags follow the synchroniser
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      tag1 <= 1'b0;
      tag2 <= 1'b0;
      tag1_beat <= 2'h0;
      tag2_beat <= 2'h0;
    end
    else
    begin
      tag1 <= mem_strobe_o && !mem_we_o;
      tag2 <= tag1;
      tag1_beat <= mem_addr_o[1:0] - base_addr[1:0];
      tag2_beat <= tag1_beat;
    end
  end

  // Collect each byte lane of the even-first image
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          rd_img[31 - 8 * gi -: 8] <= 8'h0;
        end
        else if (tag2)
        begin
          unique case (acc_width)
            `MW_16:
            begin
              if (tag2_beat[0] == 1'(gi / 2))
              begin
                rd_img[31 - 8 * gi -: 8] <= rd_sync[15 - 8 * (gi % 2) -: 8];
              end
            end
            `MW_8:
            begin
              if (tag2_beat == 2'(gi))
              begin
                rd_img[31 - 8 * gi -: 8] <= rd_sync[7:0];
              end
            end
            default:
            begin
              rd_img[31 - 8 * gi -: 8] <= rd_sync[31 - 8 * gi -: 8];
            end
          endcase
        end
      end
    end
  endgenerate

  // Reorder or isolate the returned data
  always_comb
  begin
    if (acc_size32)
    begin
      next_rdata = acc_addr[1] ? {rd_img[15:0], rd_img[31:16]} : rd_img;
    end
    else
    begin
      next_rdata = {16'h0, acc_addr[1] ? rd_img[15:0] : rd_img[31:16]};
    end
  end

  assign resp_push = (state == ST_RESP);
  assign resp_sel_ready = resp_data[32] ? dma_resp_ready_i : cpu_resp_ready_i;

  // Response buffer, stalls the sequencer when full
  resp_buffer #(
    .WIDTH(33)
  ) u_resp (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(resp_push),
    .in_ready_o(resp_ready),
    .in_data_i({acc_src, acc_we ? 32'h0 : next_rdata}),
    .out_valid_o(resp_valid),
    .out_ready_i(resp_sel_ready),
    .out_data_o(resp_data)
  );

  // Split response per source
  assign cpu_resp_valid_o = resp_valid && !resp_data[32];
  assign dma_resp_valid_o = resp_valid && resp_data[32];
  assign cpu_rdata_hi_o = resp_data[31:16];
  assign cpu_rdata_lo_o = resp_data[15:0];
  assign dma_rdata_o = resp_data[31:0];

  chk_be_w32_full: assert property (@(posedge clock_i) disable iff (reset_i)
    mem_strobe_o && acc_width == `MW_32 && acc_size32 |-> mem_byte_lane_enable_n_o == `BE_ALL)
    else $error("32-bit access on 32-wide memory lacks all lanes");
  chk_be_w16_lanes: assert property (@(posedge clock_i) disable iff (reset_i)
    mem_strobe_o && acc_width == `MW_16 |-> mem_byte_lane_enable_n_o == `BE_LO)
    else $error("16-wide memory lanes wrong");
  chk_be_w8_lane: assert property (@(posedge clock_i) disable iff (reset_i)
    mem_strobe_o && acc_width == `MW_8 |-> mem_byte_lane_enable_n_o == `BE_B0)
    else $error("8-wide memory lane wrong");
  chk_two_beats: assert property (@(posedge clock_i) disable iff (reset_i)
    req_valid && req_ready && !req_we && mem_width_i == `MW_16 |-> ##2 mem_strobe_o [*2] ##1 !mem_strobe_o)
    else $error("16-wide read is not two back-to-back beats");
  chk_four_beats: assert property (@(posedge clock_i) disable iff (reset_i)
    req_valid && req_ready && !req_we && mem_width_i == `MW_8 |-> ##2 mem_strobe_o [*4] ##1 !mem_strobe_o)
    else $error("8-wide read is not four back-to-back beats");
  chk_addr_step: assert property (@(posedge clock_i) disable iff (reset_i)
    mem_strobe_o && $past(mem_strobe_o) |-> mem_addr_o == $past(mem_addr_o) + 20'h1)
    else $error("second beat address not incremented");
  chk_half_write_hi: assert property (@(posedge clock_i) disable iff (reset_i)
    mem_strobe_o && mem_we_o && acc_width == `MW_32 && !acc_size32 && !acc_addr[1]
    |-> mem_byte_lane_enable_n_o == `BE_HI && !mem_data_oe_n_o)
    else $error("even word write lanes wrong");
  chk_half_write_lo: assert property (@(posedge clock_i) disable iff (reset_i)
    mem_strobe_o && mem_we_o && acc_width == `MW_32 && !acc_size32 && acc_addr[1]
    |-> mem_byte_lane_enable_n_o == `BE_LO)
    else $error("odd word write lanes wrong");
  chk_half_read_pick: assert property (@(posedge clock_i) disable iff (reset_i)
    mem_strobe_o && !mem_we_o && acc_width == `MW_32 && !acc_size32
    |-> ##3 resp_push && next_rdata == {16'h0, acc_addr[1] ? $past(mem_data_i[15:0], 3) : $past(mem_data_i[31:16], 3)})
    else $error("16-bit read returned wrong half");
  chk_resp_after: assert property (@(posedge clock_i) disable iff (reset_i)
    resp_push |-> !tag1 && !tag2 && !(mem_strobe_o && !mem_we_o))
    else $error("response before all beats finished");

endmodule
`default_nettype wire

// [src/lane_steer_params.svh]
/*
  Constants for the data width lane steering bridge.
  Assumes it is included by bare name from the package and modules.
*/
`ifndef LANE_STEER_PARAMS_SVH
`define LANE_STEER_PARAMS_SVH

// Memory width codes on mem_width_i
`define MW_32 2'h0
`define MW_16 2'h1
`define MW_8 2'h2

// Byte lane enable patterns, active low, [3:0]
`define BE_ALL 4'h0
`define BE_HI 4'h3
`define BE_LO 4'hC
`define BE_B0 4'hE
`define BE_NONE 4'hF

// Index of last beat per memory width
`define LAST_32 2'h0
`define LAST_16 2'h1
`define LAST_8 2'h3

// Bus widths
`define IADDR_W 22
`define XADDR_W 20
`define HALF_W 16
`define WORD_W 32

`endif

// [src/lane_steer_pkg.sv]
/*
  Types for the data width lane steering bridge.
  Assumes lane_steer_params.svh is on the include path.
*/
`include "lane_steer_params.svh"

package lane_steer_pkg;

  // Memory width code
  typedef logic [1:0] mem_width_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_XFER = 4'h2,
    ST_DRAIN = 4'h4,
    ST_RESP = 4'h8
  } state_t;

endpackage

// [src/request_arbiter.sv]
/*
  Round-robin choice between the CPU data port and the DMA port.
  Assumes requesters hold their fields stable while req is high.
*/
`timescale 1ns/10ps
`default_nettype none

module request_arbiter (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic cpu_size32_i,
  input wire logic [21:0] cpu_addr_i,
  input wire logic [31:0] cpu_wdata_i,
  output logic cpu_ready_o,
  input wire logic dma_req_i,
  input wire logic dma_we_i,
  input wire logic dma_size32_i,
  input wire logic [21:0] dma_addr_i,
  input wire logic [31:0] dma_wdata_i,
  output logic dma_ready_o,
  output logic req_valid_o,
  input wire logic req_ready_i,
  output logic req_src_o,
  output logic req_we_o,
  output logic req_size32_o,
  output logic [21:0] req_addr_o,
  output logic [31:0] req_wdata_o
);

  // Last served source, 1 = DMA
  logic last_dma;
  // DMA wins when alone or when CPU was served last
  logic pick_dma;

  assign pick_dma = dma_req_i && (!cpu_req_i || !last_dma);
  assign req_valid_o = cpu_req_i || dma_req_i;
  assign req_src_o = pick_dma;
  assign req_we_o = pick_dma ? dma_we_i : cpu_we_i;
  assign req_size32_o = pick_dma ? dma_size32_i : cpu_size32_i;
  assign req_addr_o = pick_dma ? dma_addr_i : cpu_addr_i;
  assign req_wdata_o = pick_dma ? dma_wdata_i : cpu_wdata_i;
  assign cpu_ready_o = req_ready_i && !pick_dma;
  assign dma_ready_o = req_ready_i && pick_dma;

  // Remember who was served
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      last_dma <= 1'b0;
    end
    else if (req_valid_o && req_ready_i)
    begin
      last_dma <= pick_dma;
    end
  end

endmodule
`default_nettype wire

// [src/resp_buffer.sv]
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module resp_buffer #(
  parameter int WIDTH = 33
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  // Two storage slots
  logic [WIDTH-1:0] slot [2];
  // Write and read pointers
  logic wr_ptr;
  logic rd_ptr;
  // Fill level 0..2
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = slot[rd_ptr];

  // Store incoming word
  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      slot[wr_ptr] <= in_data_i;
    end
  end

  // Pointer and level update
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule
`default_nettype wire

// [test/mem_model.sv]
/*
  Behavioural external memory: one 32-bit word per address, byte lanes.
  Assumes the bridge strobes one beat per cycle and samples read data
  in the strobe cycle; no wait states are modelled.
*/
`timescale 1ns/10ps
`default_nettype none

module mem_model (
  input wire logic clock_i,
  input wire logic strobe_i,
  input wire logic we_i,
  input wire logic [19:0] addr_i,
  input wire logic [3:0] byte_lane_enable_n_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o
);
  logic [31:0] mem [0:1023]; // Word storage, low ten address bits
  logic [31:0] last = 32'h0; // Last word driven on a read

  // Store only lanes whose enable is low
  always @(posedge clock_i)
  begin
    if (strobe_i && we_i)
      for (int i = 0; i < 4; i++)
        if (!byte_lane_enable_n_i[i])
          mem[addr_i[9:0]][8*i +: 8] <= data_i[8*i +: 8];
    if (strobe_i && !we_i)
      last <= data_o;
  end

  // Read in the strobe cycle; a released bus shows the inverse of the last word
  always @(*)
  begin
    if (strobe_i && !we_i)
      data_o = mem[addr_i[9:0]];
    else
      data_o = ~last;
  end
endmodule

`default_nettype wire

// [test/tb_top.sv]
/*
  Self-checking bench for the lane steering bridge and its memory model.
  Assumes the design files and mem_model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lane_steer_params.svh"

module tb_top;
  import lane_steer_pkg::*;

  // Port, width, write, size32, address, data, expected answer
  typedef struct packed {
    logic p;
    logic [1:0] w;
    logic we;
    logic sz;
    logic [21:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  // One expected memory beat
  typedef struct packed {
    logic [19:0] addr;
    logic [3:0] be;
    logic we;
    logic [31:0] data;
    logic [31:0] mask;
  } beat_t;

  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  mem_width_t mem_width_i = `MW_32;
  logic cpu_req_i = 1'b0, cpu_we_i = 1'b0, cpu_size32_i = 1'b0, cpu_resp_ready_i = 1'b1;
  logic dma_req_i = 1'b0, dma_we_i = 1'b0, dma_size32_i = 1'b0, dma_resp_ready_i = 1'b1;
  logic [21:0] cpu_addr_i = 22'h0, dma_addr_i = 22'h0;
  logic [15:0] cpu_wdata_hi_i = 16'h0, cpu_wdata_lo_i = 16'h0, cpu_rdata_hi_o, cpu_rdata_lo_o;
  logic [31:0] dma_wdata_i = 32'h0, dma_rdata_o, mem_data_i, mem_data_o;
  logic cpu_ready_o, cpu_resp_valid_o, dma_ready_o, dma_resp_valid_o;
  logic mem_strobe_o, mem_we_o, mem_data_oe_n_o, tc, td;
  logic [19:0] mem_addr_o;
  logic [3:0] mem_byte_lane_enable_n_o;
  int fails = 0, num_checks = 0, cycles = 0; // Counters
  beat_t exp_q [$]; // Beats still expected on the pins
  beat_t mb; // Beat being matched
  // Ordinary cases, run in order; DMA 32-bit rows keep the MSW even
  row_t rows [21] = '{
    '{0,0,1,1,22'h000010,32'h12345678,32'h0},
    '{1,0,0,1,22'h000010,32'h0,32'h12345678},
    '{0,0,1,1,22'h000022,32'hAABBCCDD,32'h0},
    '{0,0,0,1,22'h000022,32'h0,32'hAABBCCDD},
    '{0,0,0,0,22'h000020,32'h0,32'h0000CCDD},
    '{0,0,1,0,22'h000022,32'h00005A5A,32'h0},
    '{0,0,0,1,22'h000022,32'h0,32'h5A5ACCDD},
    '{1,0,1,0,22'h000020,32'h00001357,32'h0},
    '{0,0,0,1,22'h000020,32'h0,32'h13575A5A},
    '{0,3,0,1,22'h000010,32'h0,32'h12345678},
    '{0,1,1,1,22'h000102,32'h11223344,32'h0},
    '{0,1,0,1,22'h000102,32'h0,32'h11223344},
    '{1,1,0,1,22'h000100,32'h0,32'h33441122},
    '{0,1,1,0,22'h000100,32'h0000BEEF,32'h0},
    '{0,1,0,0,22'h000102,32'h0,32'h00001122},
    '{1,1,0,0,22'h000100,32'h0,32'h0000BEEF},
    '{1,2,1,1,22'h000200,32'hCAFEF00D,32'h0},
    '{0,2,0,1,22'h000202,32'h0,32'hF00DCAFE},
    '{0,2,1,0,22'h000202,32'h00004321,32'h0},
    '{0,2,0,0,22'h000200,32'h0,32'h0000CAFE},
    '{0,2,0,1,22'h000200,32'h0,32'hCAFE4321}};

  // 125 MHz clock
  always #4 clock_i = ~clock_i;

  lane_steer lane_steer_i (.clock_i, .reset_i, .mem_width_i, .cpu_req_i, .cpu_we_i, .cpu_size32_i,
    .cpu_addr_i, .cpu_wdata_hi_i, .cpu_wdata_lo_i, .cpu_ready_o, .cpu_resp_valid_o, .cpu_resp_ready_i,
    .cpu_rdata_hi_o, .cpu_rdata_lo_o, .dma_req_i, .dma_we_i, .dma_size32_i, .dma_addr_i, .dma_wdata_i,
    .dma_ready_o, .dma_resp_valid_o, .dma_resp_ready_i, .dma_rdata_o, .mem_addr_o,
    .mem_byte_lane_enable_n_o, .mem_strobe_o, .mem_we_o, .mem_data_i, .mem_data_o, .mem_data_oe_n_o);

  mem_model mem_model_i (.clock_i, .strobe_i(mem_strobe_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .byte_lane_enable_n_i(mem_byte_lane_enable_n_o), .data_i(mem_data_o), .data_o(mem_data_i));

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Expected beats: even-first image cut from the top, one slice per beat
  task automatic plan(input logic [1:0] w, input logic we, input logic sz, input logic [21:0] a,
                      input logic [31:0] d);
    int n;
    logic [1:0] v;
    logic [31:0] img;
    beat_t b;
    v = (w == 2'h3) ? `MW_32 : w;
    n = 1 << v;
    img = sz ? (a[1] ? {d[15:0], d[31:16]} : d) : {d[15:0], d[15:0]};
    b.be = (v == `MW_16) ? `BE_LO : (v == `MW_8) ? `BE_B0 : `BE_ALL;
    if (v == `MW_32 && we && !sz)
      b.be = a[1] ? `BE_LO : `BE_HI;
    b.we = we;
    b.mask = we ? {{8{~b.be[3]}}, {8{~b.be[2]}}, {8{~b.be[1]}}, {8{~b.be[0]}}} : 32'h0;
    for (int i = 0; i < n; i++)
      if (!we || sz || n == 1 || (i * 2 / n) == a[1])
      begin
        b.addr = (v == `MW_32) ? a[21:2] : (v == `MW_16) ? {a[20:2], 1'b0} : {a[19:2], 2'b00};
        b.addr = b.addr + 20'(i);
        b.data = img >> (8 * (4 >> v) * (n - 1 - i));
        exp_q.push_back(b);
      end
  endtask

  // One access through either port, waiting on ready and on the response
  task automatic access(input row_t r);
    int k;
    k = 0;
    plan(r.w, r.we, r.sz, r.a, r.d);
    mem_width_i = r.w;
    {cpu_we_i, cpu_size32_i, cpu_addr_i} = {r.we, r.sz, r.a};
    {dma_we_i, dma_size32_i, dma_addr_i} = {r.we, r.sz, r.a};
    {cpu_wdata_hi_i, cpu_wdata_lo_i} = r.d;
    dma_wdata_i = r.d;
    {dma_req_i, cpu_req_i} = {r.p, !r.p};
    #1;
    while (!(r.p ? dma_ready_o : cpu_ready_o) && k < 50)
    begin
      @(negedge clock_i);
      #1;
      k++;
    end
    @(negedge clock_i);
    {dma_req_i, cpu_req_i} = 2'b00;
    #1;
    while (!(r.p ? dma_resp_valid_o : cpu_resp_valid_o) && k < 100)
    begin
      @(negedge clock_i);
      #1;
      k++;
    end
    check("resp_valid", 32'(r.p ? dma_resp_valid_o : cpu_resp_valid_o), 32'h1);
    check("rdata", r.p ? dma_rdata_o : {cpu_rdata_hi_o, cpu_rdata_lo_o}, r.e);
    check("beats_left", 32'(exp_q.size()), 32'h0);
    @(negedge clock_i);
  endtask

  // Match each strobed beat mid-cycle; cut a hang short
  always @(negedge clock_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      report_and_stop();
    end
    else if (!reset_i && mem_strobe_o)
    begin
      if (exp_q.size() == 0)
        check("extra_beat", 32'h1, 32'h0);
      else
      begin
        mb = exp_q.pop_front();
        check("beat_addr", 32'(mem_addr_o), 32'(mb.addr));
        check("beat_be", 32'(mem_byte_lane_enable_n_o), 32'(mb.be));
        check("beat_we", 32'({mem_we_o, mem_data_oe_n_o}), 32'({mb.we, ~mb.we}));
        check("beat_data", mem_data_o & mb.mask, mb.data & mb.mask);
      end
    end
  end

  // Reset, table, then both ports at once with responses stalled
  initial
  begin
    repeat (20) @(negedge clock_i);
    reset_i = 1'b0;
    @(negedge clock_i);
    check("idle_pins", 32'({mem_byte_lane_enable_n_o, mem_data_oe_n_o}), 32'h1F);
    check("idle_resp", 32'({cpu_resp_valid_o, dma_resp_valid_o}), 32'h0);
    foreach (rows[i])
      access(rows[i]);
    plan(`MW_32, 1'b0, 1'b0, 22'h000010, 32'h0);
    plan(`MW_32, 1'b0, 1'b1, 22'h000010, 32'h0);
    {cpu_resp_ready_i, dma_resp_ready_i} = 2'b00;
    {cpu_we_i, cpu_size32_i, dma_we_i, dma_size32_i} = 4'b0001;
    {cpu_addr_i, dma_addr_i} = {22'h000010, 22'h000010};
    mem_width_i = `MW_32;
    {cpu_req_i, dma_req_i} = 2'b11;
    repeat (40)
    begin
      #1;
      tc = cpu_req_i && cpu_ready_o;
      td = dma_req_i && dma_ready_o;
      @(negedge clock_i);
      if (tc)
        cpu_req_i = 1'b0;
      if (td)
        dma_req_i = 1'b0;
    end
    // DMA won the round, so its answer heads the shared buffer
    check("stall_valid", 32'({cpu_resp_valid_o, dma_resp_valid_o}), 32'h1);
    check("stall_dma", dma_rdata_o, 32'h12345678);
    check("stall_beats", 32'(exp_q.size()), 32'h0);
    dma_resp_ready_i = 1'b1;
    @(negedge clock_i);
    check("stall_next", 32'({cpu_resp_valid_o, dma_resp_valid_o}), 32'h2);
    check("stall_cpu", {cpu_rdata_hi_o, cpu_rdata_lo_o}, 32'h00001234);
    cpu_resp_ready_i = 1'b1;
    @(negedge clock_i);
    check("drained", 32'({cpu_resp_valid_o, dma_resp_valid_o}), 32'h0);
    // Reset again mid-run; pins go idle and the next access still works
    reset_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check("reset_pins", 32'({mem_strobe_o, mem_byte_lane_enable_n_o, mem_data_oe_n_o}), 32'h1F);
    reset_i = 1'b0;
    @(negedge clock_i);
    access(rows[1]);
    report_and_stop();
  end
endmodule

`default_nettype wire
